/* File: src/radio_coex_map.svh */
// constants for the radio stream and coexistence signalling block
// assumes a 100 MHz core clock and a 1 us stream bit period
`ifndef RADIO_COEX_MAP_SVH
`define RADIO_COEX_MAP_SVH

// ==========================================================
// timing
`define RC_CORE_CLK_PERIOD_NS 10
`define RC_STREAM_BIT_PERIOD_NS 1000
`define RC_STREAM_DIV_CYCLES ((`RC_STREAM_BIT_PERIOD_NS + `RC_CORE_CLK_PERIOD_NS - 1) / `RC_CORE_CLK_PERIOD_NS)
`define RC_STREAM_HALF_CYCLES (`RC_STREAM_DIV_CYCLES / 2)
`define RC_STREAM_DIV_WIDTH 7

// ==========================================================
// stream word layout
`define RC_BYTE_WIDTH 8
`define RC_LAST_BIT_INDEX 7
`define RC_XFER_WIDTH 10
`define RC_XFER_FIRST_POS 8
`define RC_XFER_LAST_POS 9

// ==========================================================
// reset values
`define RC_SHIFT_RESET 8'h00
`define RC_BITCNT_RESET 3'h0
`define RC_DIV_RESET 7'h00

`endif

/* File: src/radio_coex_pkg.sv */
// types for the radio stream and coexistence signalling block
// assumes nothing of its surroundings
package radio_coex_pkg;

  // ==========================================================
  // stream serialiser states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01
  } stream_state_t;

  // ==========================================================
  // front-end switch selection
  typedef enum logic [1:0]
  {
    FEM_OFF = 2'b00,
    FEM_RX = 2'b01,
    FEM_TX = 2'b10
  } fem_mode_t;

endpackage

/* File: src/level_sync.sv */
// two-flop synchroniser for a group of levels
// assumes inputs are quasi-static levels from another domain or a pin
`timescale 1ns/1ps

module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  // ==========================================================
  // next values
  always_comb
  begin
    meta_d = d;
    stable_d = meta_q;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      stable_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign q = stable_q;

endmodule

/* File: src/word_handshake_cdc.sv */
// toggle handshake carrying one word from a source clock to a destination clock
// assumes both sides share one asynchronous active-low reset
`timescale 1ns/1ps

module word_handshake_cdc #(
  parameter int WIDTH = 10
) (
  // source side
  input wire logic src_clk,
  input wire logic resetn,
  input wire logic src_valid,
  input wire logic [WIDTH-1:0] src_data,
  output logic src_ready,
  // destination side
  input wire logic dst_clk,
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_data,
  input wire logic dst_ready
);

  logic req_q;
  logic req_d;
  logic [WIDTH-1:0] hold_q;
  logic [WIDTH-1:0] hold_d;
  logic ack_seen;
  logic ack_q;
  logic ack_d;
  logic req_seen;
  logic req_last_q;
  logic req_last_d;
  logic full_q;
  logic full_d;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // ==========================================================
  // source domain
  level_sync #(.WIDTH(1)) u_ack_sync (
    .clk(src_clk),
    .resetn(resetn),
    .d(ack_q),
    .q(ack_seen)
  );

  assign src_ready = (req_q == ack_seen);

  always_comb
  begin
    req_d = req_q;
    hold_d = hold_q;
    if (src_valid && src_ready)
    begin
      req_d = ~req_q;
      hold_d = src_data;
    end
  end

  always_ff @(posedge src_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_q <= 1'b0;
      hold_q <= '0;
    end
    else
    begin
      req_q <= req_d;
      hold_q <= hold_d;
    end
  end

  // ==========================================================
  // destination domain
  level_sync #(.WIDTH(1)) u_req_sync (
    .clk(dst_clk),
    .resetn(resetn),
    .d(req_q),
    .q(req_seen)
  );

  always_comb
  begin
    req_last_d = req_last_q;
    full_d = full_q;
    out_d = out_q;
    ack_d = ack_q;
    if (full_q && dst_ready)
    begin
      full_d = 1'b0;
      ack_d = ~ack_q;
    end
    else if (!full_q && (req_seen != req_last_q))
    begin
      req_last_d = req_seen;
      full_d = 1'b1;
      out_d = hold_q;
    end
  end

  always_ff @(posedge dst_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_last_q <= 1'b0;
      full_q <= 1'b0;
      out_q <= '0;
      ack_q <= 1'b0;
    end
    else
    begin
      req_last_q <= req_last_d;
      full_q <= full_d;
      out_q <= out_d;
      ack_q <= ack_d;
    end
  end

  assign dst_valid = full_q;
  assign dst_data = out_q;

endmodule

/* File: src/radio_coex_signals.sv */
// radio stream and coexistence signalling: stream serialiser, coex outputs, oscillator requests
// assumes link-layer inputs on radio_clk, pins asynchronous, controls on core_clk
// Functional notes
// RULE_01 - radio activity output rises before each radio event and holds throughout it
// RULE_02 - stream clock toggles at one bit per microsecond while stream mode is on
// RULE_03 - stream data and frame change together, stable at stream clock rising edge
// RULE_04 - external receiver samples frame and data on each stream clock rising edge
// RULE_05 - received packet bytes go out one bit per clock, least significant first
// RULE_06 - frame output goes high to mark a reception start, active high
// RULE_07 - busy indicator shows receive or transmit event; software can force it
// RULE_08 - priority output tells the other radio this event needs the antenna
// RULE_09 - early wake output asserts ahead of each radio event
// RULE_10 - inhibit input stops all internal radio activity; a forced busy value still shows under inhibit
// RULE_11 - other radio reports antenna availability on a general-purpose input
// RULE_12 - two front-end controls: one selects receive, one selects transmit
// RULE_13 - external oscillator-on request turns on the internal RF oscillator
// RULE_14 - external oscillator request when radio needs it or system runs on RF oscillator
// RULE_15 - reference clock reaches its output pin only while its enable is high
// RULE_16 - receive and transmit front-end controls never high together
`timescale 1ns/1ps
`include "radio_coex_map.svh"

module radio_coex_signals (
  // core clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // link-layer clock
  input wire logic radio_clk,
  // link-layer event state, radio_clk domain
  input wire logic ll_event_pending,
  input wire logic ll_rx_event,
  input wire logic ll_tx_event,
  input wire logic ll_high_priority,
  input wire logic ll_early_warning,
  input wire logic ll_needs_ext_osc,
  // received packet bytes, radio_clk domain
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_first,
  input wire logic rx_byte_last,
  output logic rx_byte_ready,
  // core-side controls
  input wire logic bit_stream_mode,
  input wire logic status_force_en,
  input wire logic status_force_value,
  input wire logic sys_clk_on_rf_osc,
  // pins from outside
  input wire logic radio_inhibit_in,
  input wire logic antenna_grant_in,
  input wire logic osc_on_request_in,
  input wire logic ref_clock_output_enable,
  input wire logic ref_clk_in,
  // coexistence and status outputs
  output logic radio_event_active_out,
  output logic radio_busy_indicator,
  output logic coex_priority_out,
  output logic pre_event_wake_out,
  output logic radio_stop_out,
  output logic fem_rx_switch_out,
  output logic fem_tx_switch_out,
  // oscillator requests
  output logic internal_osc_request,
  output logic external_osc_request_out,
  // bit stream
  output logic stream_clock_out,
  output logic stream_data_out,
  output logic stream_frame_out,
  // reference clock
  output logic ref_clock_output
);

  // ==========================================================
  // helpers
  function automatic radio_coex_pkg::fem_mode_t fem_decode(input logic rx, input logic tx, input logic grant);
    radio_coex_pkg::fem_mode_t m;
    m = radio_coex_pkg::FEM_OFF;
    if (tx && grant)
    begin
      m = radio_coex_pkg::FEM_TX;
    end
    else if (rx)
    begin
      m = radio_coex_pkg::FEM_RX;
    end
    return m;
  endfunction

  // ==========================================================
  // crossings
  logic [5:0] ll_sync;
  logic [2:0] pin_sync;
  logic ev_pending;
  logic ev_rx;
  logic ev_tx;
  logic ev_hp;
  logic ev_warn;
  logic ev_ext_osc;
  logic inhibit;
  logic grant;
  logic osc_req;

  level_sync #(.WIDTH(6)) u_ll_sync (
    .clk(core_clk),
    .resetn(resetn),
    .d({ll_event_pending, ll_rx_event, ll_tx_event, ll_high_priority, ll_early_warning, ll_needs_ext_osc}),
    .q(ll_sync)
  );

  level_sync #(.WIDTH(3)) u_pin_sync (
    .clk(core_clk),
    .resetn(resetn),
    .d({radio_inhibit_in, antenna_grant_in, osc_on_request_in}),
    .q(pin_sync)
  );

  assign ev_pending = ll_sync[5];
  assign ev_rx = ll_sync[4];
  assign ev_tx = ll_sync[3];
  assign ev_hp = ll_sync[2];
  assign ev_warn = ll_sync[1];
  assign ev_ext_osc = ll_sync[0];
  assign inhibit = pin_sync[2];
  assign grant = pin_sync[1];
  assign osc_req = pin_sync[0];

  logic byte_valid;
  logic [`RC_XFER_WIDTH-1:0] byte_word;
  logic byte_take;

  word_handshake_cdc #(.WIDTH(`RC_XFER_WIDTH)) u_byte_cdc (
    .src_clk(radio_clk),
    .resetn(resetn),
    .src_valid(rx_byte_valid),
    .src_data({rx_byte_last, rx_byte_first, rx_byte}),
    .src_ready(rx_byte_ready),
    .dst_clk(core_clk),
    .dst_valid(byte_valid),
    .dst_data(byte_word),
    .dst_ready(byte_take)
  );

  // ==========================================================
  // coexistence outputs
  logic active_q;
  logic active_d;
  logic busy_q;
  logic busy_d;
  logic prio_q;
  logic prio_d;
  logic warn_q;
  logic warn_d;
  logic stop_q;
  logic stop_d;
  logic fem_rx_q;
  logic fem_rx_d;
  logic fem_tx_q;
  logic fem_tx_d;
  logic int_osc_q;
  logic int_osc_d;
  logic ext_osc_q;
  logic ext_osc_d;
  radio_coex_pkg::fem_mode_t fem_mode;

  always_comb
  begin
    fem_mode = fem_decode(ev_rx, ev_tx, grant); // RULE_11
    active_d = (ev_pending | ev_rx | ev_tx) & ~inhibit; // RULE_01 RULE_10
    if (status_force_en)
    begin
      busy_d = status_force_value; // RULE_07
    end
    else
    begin
      busy_d = (ev_rx | ev_tx) & ~inhibit; // RULE_07
    end
    prio_d = ev_hp & (ev_pending | ev_rx | ev_tx) & ~inhibit; // RULE_08
    warn_d = ev_warn & ~inhibit; // RULE_09
    stop_d = inhibit; // RULE_10
    fem_rx_d = (fem_mode == radio_coex_pkg::FEM_RX) & ~inhibit; // RULE_12 RULE_16
    fem_tx_d = (fem_mode == radio_coex_pkg::FEM_TX) & ~inhibit; // RULE_12 RULE_16
    int_osc_d = osc_req; // RULE_13
    ext_osc_d = ev_ext_osc | sys_clk_on_rf_osc; // RULE_14
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      active_q <= 1'b0;
      busy_q <= 1'b0;
      prio_q <= 1'b0;
      warn_q <= 1'b0;
      stop_q <= 1'b0;
      fem_rx_q <= 1'b0;
      fem_tx_q <= 1'b0;
      int_osc_q <= 1'b0;
      ext_osc_q <= 1'b0;
    end
    else
    begin
      active_q <= active_d;
      busy_q <= busy_d;
      prio_q <= prio_d;
      warn_q <= warn_d;
      stop_q <= stop_d;
      fem_rx_q <= fem_rx_d;
      fem_tx_q <= fem_tx_d;
      int_osc_q <= int_osc_d;
      ext_osc_q <= ext_osc_d;
    end
  end

  assign radio_event_active_out = active_q;
  assign radio_busy_indicator = busy_q;
  assign coex_priority_out = prio_q;
  assign pre_event_wake_out = warn_q;
  assign radio_stop_out = stop_q;
  assign fem_rx_switch_out = fem_rx_q;
  assign fem_tx_switch_out = fem_tx_q;
  assign internal_osc_request = int_osc_q;
  assign external_osc_request_out = ext_osc_q;

  // ==========================================================
  // stream clock divider
  logic [`RC_STREAM_DIV_WIDTH-1:0] div_q;
  logic [`RC_STREAM_DIV_WIDTH-1:0] div_d;
  logic sclk_q;
  logic sclk_d;
  logic bit_tick;

  always_comb
  begin
    bit_tick = 1'b0;
    div_d = `RC_DIV_RESET;
    if (bit_stream_mode)
    begin
      if (div_q == `RC_STREAM_DIV_WIDTH'(`RC_STREAM_DIV_CYCLES - 1))
      begin
        bit_tick = 1'b1; // RULE_02
      end
      else
      begin
        div_d = div_q + `RC_STREAM_DIV_WIDTH'(1); // RULE_02
      end
    end
    sclk_d = bit_stream_mode && (div_d >= `RC_STREAM_DIV_WIDTH'(`RC_STREAM_HALF_CYCLES)); // RULE_02
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q <= `RC_DIV_RESET;
      sclk_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      sclk_q <= sclk_d;
    end
  end

  assign stream_clock_out = sclk_q;

  // ==========================================================
  // stream serialiser
  radio_coex_pkg::stream_state_t state_q;
  radio_coex_pkg::stream_state_t state_d;
  logic [`RC_BYTE_WIDTH-1:0] shift_q;
  logic [`RC_BYTE_WIDTH-1:0] shift_d;
  logic [2:0] bitcnt_q;
  logic [2:0] bitcnt_d;
  logic last_q;
  logic last_d;
  logic data_q;
  logic data_d;
  logic frame_q;
  logic frame_d;
  logic next_first;
  logic next_last;
  logic [`RC_BYTE_WIDTH-1:0] next_byte;

  assign next_byte = byte_word[`RC_BYTE_WIDTH-1:0];
  assign next_first = byte_word[`RC_XFER_FIRST_POS];
  assign next_last = byte_word[`RC_XFER_LAST_POS];

  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    bitcnt_d = bitcnt_q;
    last_d = last_q;
    data_d = data_q;
    frame_d = frame_q;
    byte_take = 1'b0;
    if (!bit_stream_mode || inhibit)
    begin
      state_d = radio_coex_pkg::ST_IDLE; // RULE_10
      data_d = 1'b0;
      frame_d = 1'b0;
      byte_take = byte_valid;
    end
    else if (bit_tick)
    begin
      case (state_q)
        radio_coex_pkg::ST_IDLE:
        begin
          byte_take = byte_valid;
          if (byte_valid && next_first)
          begin
            state_d = radio_coex_pkg::ST_SHIFT;
            shift_d = next_byte;
            bitcnt_d = `RC_BITCNT_RESET;
            last_d = next_last;
            data_d = next_byte[0]; // RULE_05 RULE_03
            frame_d = 1'b1; // RULE_06 RULE_03
          end
        end
        radio_coex_pkg::ST_SHIFT:
        begin
          if (bitcnt_q != 3'(`RC_LAST_BIT_INDEX))
          begin
            shift_d = shift_q >> 1;
            bitcnt_d = bitcnt_q + 3'h1;
            data_d = shift_q[1]; // RULE_05 RULE_03
          end
          else if (!last_q && byte_valid && !next_first)
          begin
            byte_take = 1'b1;
            shift_d = next_byte;
            bitcnt_d = `RC_BITCNT_RESET;
            last_d = next_last;
            data_d = next_byte[0]; // RULE_05 RULE_03
          end
          else
          begin
            state_d = radio_coex_pkg::ST_IDLE;
            data_d = 1'b0;
            frame_d = 1'b0; // RULE_03
          end
        end
        default:
        begin
          state_d = radio_coex_pkg::ST_IDLE;
          data_d = 1'b0;
          frame_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= radio_coex_pkg::ST_IDLE;
      shift_q <= `RC_SHIFT_RESET;
      bitcnt_q <= `RC_BITCNT_RESET;
      last_q <= 1'b0;
      data_q <= 1'b0;
      frame_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      bitcnt_q <= bitcnt_d;
      last_q <= last_d;
      data_q <= data_d;
      frame_q <= frame_d;
    end
  end

  assign stream_data_out = data_q;
  assign stream_frame_out = frame_q;

  // ==========================================================
  // reference clock gate
  logic refen_sync;
  logic ref_gate_q;
  logic ref_gate_d;

  level_sync #(.WIDTH(1)) u_refen_sync (
    .clk(ref_clk_in),
    .resetn(resetn),
    .d(ref_clock_output_enable),
    .q(refen_sync)
  );

  always_comb
  begin
    ref_gate_d = refen_sync;
  end

  always_ff @(negedge ref_clk_in or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_gate_q <= 1'b0;
    end
    else
    begin
      ref_gate_q <= ref_gate_d;
    end
  end

  assign ref_clock_output = ref_clk_in & ref_gate_q; // RULE_15

endmodule

/* File: dv/radio_coex_signals_props.sv */
// concurrent checks on the radio stream and coexistence block
// assumes it is bound to radio_coex_signals and watches its core_clk ports only
`timescale 1ns/1ps

module radio_coex_signals_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // inputs watched
  input wire logic ll_tx_event,
  input wire logic ll_rx_event,
  input wire logic ll_early_warning,
  input wire logic bit_stream_mode,
  input wire logic status_force_en,
  input wire logic status_force_value,
  input wire logic sys_clk_on_rf_osc,
  input wire logic radio_inhibit_in,
  input wire logic antenna_grant_in,
  input wire logic osc_on_request_in,
  // outputs watched
  input wire logic radio_event_active_out,
  input wire logic radio_busy_indicator,
  input wire logic coex_priority_out,
  input wire logic pre_event_wake_out,
  input wire logic radio_stop_out,
  input wire logic fem_rx_switch_out,
  input wire logic fem_tx_switch_out,
  input wire logic internal_osc_request,
  input wire logic external_osc_request_out,
  input wire logic stream_clock_out,
  input wire logic stream_data_out,
  input wire logic stream_frame_out
);
  localparam int HALF = 49;
  logic clk_q;
  logic seen_q;
  logic seen_d;
  logic [6:0] half_q;
  logic [6:0] half_d;

  // ====================================
  // stream clock half-period counter
  always_comb
  begin
    half_d = (clk_q != stream_clock_out) ? 7'h00 : half_q + 7'h01;
    seen_d = bit_stream_mode && (seen_q || (clk_q != stream_clock_out));
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_q <= 1'b0;
      seen_q <= 1'b0;
      half_q <= 7'h00;
    end
    else
    begin
      clk_q <= stream_clock_out;
      seen_q <= seen_d;
      half_q <= half_d;
    end
  end

  // ====================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_ACTIVE_EVENT: assert property ((ll_rx_event && !radio_inhibit_in)[*4] |-> radio_event_active_out)
    else $error("activity output low during receive event");
  AST_STREAM_HALF: assert property (disable iff (!resetn || !bit_stream_mode)
    (clk_q != stream_clock_out) && seen_q |-> half_q == HALF)
    else $error("stream clock half period not 50 cycles");
  AST_STREAM_STABLE: assert property (stream_clock_out && clk_q && !radio_stop_out |->
    $stable(stream_data_out) && $stable(stream_frame_out))
    else $error("stream data or frame moved while clock high");
  AST_FRAME_START: assert property ($rose(stream_frame_out) |-> $fell(stream_clock_out))
    else $error("frame rose away from a stream clock fall");
  AST_BUSY_FORCE: assert property ((status_force_en && status_force_value)[*3] |-> radio_busy_indicator)
    else $error("forced busy value not shown");
  AST_PRIO_ACTIVE: assert property (coex_priority_out |-> radio_event_active_out)
    else $error("priority without radio activity");
  AST_WAKE: assert property ((ll_early_warning && !radio_inhibit_in)[*4] |-> pre_event_wake_out)
    else $error("early wake not raised");
  AST_INHIBIT: assert property (radio_inhibit_in[*4] |-> radio_stop_out && !(radio_event_active_out
    || coex_priority_out || pre_event_wake_out || fem_rx_switch_out || fem_tx_switch_out))
    else $error("activity remains under inhibit");
  AST_FEM_TX: assert property ((ll_tx_event && antenna_grant_in && !radio_inhibit_in)[*4] |->
    fem_tx_switch_out)
    else $error("transmit switch not selected");
  AST_OSC_ON: assert property (osc_on_request_in[*4] |-> internal_osc_request)
    else $error("internal oscillator not requested");
  AST_EXT_OSC: assert property (sys_clk_on_rf_osc[*3] |-> external_osc_request_out)
    else $error("external oscillator not requested");
  AST_FEM_EXCL: assert property (!(fem_rx_switch_out && fem_tx_switch_out))
    else $error("both front-end switches high");

  cover property ($rose(stream_frame_out));
  cover property ($rose(fem_tx_switch_out));
  cover property ($rose(radio_stop_out));
endmodule

bind radio_coex_signals radio_coex_signals_props chk (.*);

/* File: dv/stream_capture_model.sv */
// external capture device on the bit stream pins
// assumes clear is pulsed by the bench once, before reset is released
`timescale 1ns/1ps

module stream_capture_model (
  // stream pins
  input wire logic stream_clock_out,
  input wire logic stream_frame_out,
  input wire logic stream_data_out,
  // bench side
  input wire logic clear,
  output logic [15:0] bits,
  output logic [7:0] count
);
  // ====================================
  // sample frame and data on stream clock rise
  always @(posedge stream_clock_out or posedge clear)
  begin
    if (clear)
    begin
      bits = 16'h0000;
      count = 8'h00;
    end
    else if (stream_frame_out === 1'b1)
    begin
      if (count < 8'h10)
        bits[count[3:0]] = stream_data_out;
      count = count + 8'h01;
    end
  end
endmodule

/* File: dv/test_radio_coex_signals.sv */
// self-checking bench for radio_coex_signals
// assumes the checker is bound to the design and stream_capture_model watches the stream pins
`timescale 1ns/1ps

module test_radio_coex_signals;
  logic core_clk, resetn, radio_clk, ref_clk_in, clear;
  logic ll_event_pending, ll_rx_event, ll_tx_event, ll_high_priority, ll_early_warning, ll_needs_ext_osc;
  logic rx_byte_valid, rx_byte_first, rx_byte_last, rx_byte_ready;
  logic [7:0] rx_byte;
  logic bit_stream_mode, status_force_en, status_force_value, sys_clk_on_rf_osc;
  logic radio_inhibit_in, antenna_grant_in, osc_on_request_in, ref_clock_output_enable;
  logic radio_event_active_out, radio_busy_indicator, coex_priority_out, pre_event_wake_out, radio_stop_out;
  logic fem_rx_switch_out, fem_tx_switch_out, internal_osc_request, external_osc_request_out;
  logic stream_clock_out, stream_data_out, stream_frame_out, ref_clock_output;
  logic [15:0] cap_bits;
  logic [7:0] cap_count;
  int failures = 0;
  int checks = 0;
  int ref_rises = 0;
  int sclk_rises = 0;
  wire [6:0] coex = {radio_event_active_out, radio_busy_indicator, coex_priority_out, pre_event_wake_out,
    radio_stop_out, fem_rx_switch_out, fem_tx_switch_out};

  radio_coex_signals uut (.*);

  stream_capture_model cap (.stream_clock_out(stream_clock_out), .stream_frame_out(stream_frame_out),
    .stream_data_out(stream_data_out), .clear(clear), .bits(cap_bits), .count(cap_count));

  // ====================================
  // clocks and edge counters
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    radio_clk = 1'b0;
    #13;
    forever #40 radio_clk = ~radio_clk;
  end
  initial
  begin
    ref_clk_in = 1'b0;
    forever #19 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clock_output) ref_rises++;
  always @(posedge stream_clock_out) sclk_rises++;

  // ====================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic core_wait(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic send_byte(input logic [7:0] b, input logic f, input logic l);
    int n;
    n = 0;
    @(posedge radio_clk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    rx_byte_first <= f;
    rx_byte_last <= l;
    @(negedge radio_clk);
    while (rx_byte_ready !== 1'b1 && n < 400)
    begin
      @(negedge radio_clk);
      n++;
    end
    if (n >= 400)
    begin
      failures++;
      wrap_up();
    end
    @(posedge radio_clk);
    rx_byte_valid <= 1'b0;
  endtask

  // ====================================
  // scenarios
  task automatic coex_levels();
    @(posedge core_clk);
    ll_rx_event <= 1'b1;
    core_wait(5);
    check(coex, 7'b1100010);
    @(posedge core_clk);
    ll_tx_event <= 1'b1;
    ll_high_priority <= 1'b1;
    antenna_grant_in <= 1'b1;
    core_wait(5);
    check(coex, 7'b1110001);
    @(posedge core_clk);
    antenna_grant_in <= 1'b0;
    core_wait(5);
    check(coex, 7'b1110010);
    @(posedge core_clk);
    ll_rx_event <= 1'b0;
    ll_tx_event <= 1'b0;
    ll_event_pending <= 1'b1;
    ll_early_warning <= 1'b1;
    core_wait(5);
    check(coex, 7'b1011000);
    @(posedge core_clk);
    radio_inhibit_in <= 1'b1;
    status_force_en <= 1'b1;
    status_force_value <= 1'b1;
    core_wait(5);
    check(coex, 7'b0100100);
    @(posedge core_clk);
    radio_inhibit_in <= 1'b0;
    status_force_value <= 1'b0;
    ll_rx_event <= 1'b1;
    core_wait(5);
    check(coex, 7'b1011010);
    @(posedge core_clk);
    {ll_rx_event, ll_event_pending, ll_early_warning, ll_high_priority, status_force_en} <= 5'h00;
    core_wait(5);
    check(coex, 7'b0000000);
  endtask

  task automatic osc_requests();
    @(posedge core_clk);
    osc_on_request_in <= 1'b1;
    ll_needs_ext_osc <= 1'b1;
    core_wait(5);
    check({internal_osc_request, external_osc_request_out}, 2'b11);
    @(posedge core_clk);
    ll_needs_ext_osc <= 1'b0;
    sys_clk_on_rf_osc <= 1'b1;
    core_wait(5);
    check(external_osc_request_out, 1'b1);
    @(posedge core_clk);
    {osc_on_request_in, sys_clk_on_rf_osc} <= 2'b00;
    core_wait(5);
    check({internal_osc_request, external_osc_request_out}, 2'b00);
  endtask

  task automatic ref_gate();
    @(posedge core_clk);
    ref_clock_output_enable <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    #1;
    ref_rises = 0;
    repeat (10) @(posedge ref_clk_in);
    #1;
    check(ref_rises, 10);
    @(posedge core_clk);
    ref_clock_output_enable <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    #1;
    ref_rises = 0;
    repeat (20) @(posedge ref_clk_in);
    check(ref_rises, 0);
  endtask

  task automatic stream_packet();
    int n;
    n = 0;
    @(posedge core_clk);
    bit_stream_mode <= 1'b1;
    core_wait(300);
    sclk_rises = 0;
    core_wait(1000);
    check(sclk_rises, 10);
    send_byte(8'ha5, 1'b1, 1'b0);
    send_byte(8'h3c, 1'b0, 1'b1);
    while (stream_frame_out !== 1'b0 && n < 3000)
    begin
      core_wait(1);
      n++;
    end
    if (n >= 3000)
    begin
      failures++;
      wrap_up();
    end
    check(cap_count, 16);
    check(cap_bits, 16'h3ca5);
    send_byte(8'hff, 1'b0, 1'b0);
    core_wait(1500);
    check(cap_count, 16);
    @(posedge core_clk);
    bit_stream_mode <= 1'b0;
    core_wait(200);
    check({stream_clock_out, stream_frame_out}, 2'b00);
  endtask

  // ====================================
  // main sequence
  initial
  begin
    {resetn, ll_event_pending, ll_rx_event, ll_tx_event, ll_high_priority, ll_early_warning} = 6'h00;
    {ll_needs_ext_osc, rx_byte_valid, rx_byte_first, rx_byte_last, bit_stream_mode, status_force_en} = 6'h00;
    {status_force_value, sys_clk_on_rf_osc, radio_inhibit_in, antenna_grant_in} = 4'h0;
    {osc_on_request_in, ref_clock_output_enable} = 2'b00;
    rx_byte = 8'h00;
    clear = 1'b0;
    repeat (5) @(posedge core_clk);
    clear <= 1'b1;
    @(posedge core_clk);
    resetn <= 1'b1;
    clear <= 1'b0;
    coex_levels();
    osc_requests();
    ref_gate();
    stream_packet();
    wrap_up();
  end
endmodule
